// File: hdl/sfr_pkg.sv
// Purpose: Shared constants for the register access link (device and host ends)
// Assumes: 10 MHz system clock on both ends
// Notes:   Register index 0..23 follows the device address map order
package sfr_pkg;
  localparam logic [7:0] OP_READ_ANY  = 8'h65;
  localparam logic [7:0] OP_WRITE_ANY = 8'h71;
  localparam logic [7:0] OP_WR_EN     = 8'h06;
  localparam logic [7:0] OP_WRDI      = 8'h04;
  localparam logic [7:0] OP_CLSR      = 8'h30;
  localparam logic [7:0] OP_CLSR_ALT  = 8'h82;

  localparam int         REG_COUNT  = 24;
  localparam logic [4:0] IDX_NONE   = 5'h1F;
  localparam logic [4:0] IDX_VSR1   = 5'h10;
  localparam logic [4:0] IDX_VCR2   = 5'h13;
  localparam logic [4:0] IDX_LOCK   = 5'h17;
  localparam logic [4:0] IDX_PROT   = 5'h0E;
  localparam logic [4:0] IDX_PASS0  = 5'h06;
  localparam logic [4:0] IDX_PASS7  = 5'h0D;
  localparam logic [4:0] IDX_VFIRST = 5'h10;

  localparam int BIT_RUN    = 0;
  localparam int BIT_ARM    = 1;
  localparam int BIT_EERR   = 5;
  localparam int BIT_PERR   = 6;
  localparam int BIT_ADDR4  = 7;
  localparam int BIT_PWMODE = 2;
  localparam int LAT_MSB    = 3;

  localparam logic [31:0] REG_ADDR [REG_COUNT] = '{
    32'h0000_0000, 32'h0000_0002, 32'h0000_0003, 32'h0000_0004, 32'h0000_0005, 32'h0000_0010,
    32'h0000_0020, 32'h0000_0021, 32'h0000_0022, 32'h0000_0023, 32'h0000_0024, 32'h0000_0025,
    32'h0000_0026, 32'h0000_0027, 32'h0000_0030, 32'h0000_0031, 32'h0080_0000, 32'h0080_0001,
    32'h0080_0002, 32'h0080_0003, 32'h0080_0004, 32'h0080_0005, 32'h0080_0010, 32'h0080_0040};
  localparam logic [7:0] REG_RESET [REG_COUNT] = '{
    8'h00, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h01};
  // Bits that a write never touches; status bits are hardware owned
  localparam logic [7:0] REG_RO_MASK [REG_COUNT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
  // One-time bits, default 1, may only be cleared
  localparam logic [7:0] REG_OTP_MASK [REG_COUNT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] INVALID_DATA = 8'hFF;

  localparam int CLK_MHZ          = 10;
  localparam int NV_WRITE_TIME_US = 500;
  localparam int NV_WRITE_CYCLES  = NV_WRITE_TIME_US * CLK_MHZ;
  localparam int SCK_HALF_CYCLES  = 4;
  localparam int CS_GAP_CYCLES    = 8;

  localparam logic [7:0] HREG_CTRL   = 8'h00;
  localparam logic [7:0] HREG_ADDR   = 8'h04;
  localparam logic [7:0] HREG_STATUS = 8'h08;
  localparam int CTRL_DATA_LSB = 8;
  localparam int CTRL_LAT_LSB  = 16;
  localparam int CTRL_ADDR4    = 20;
  localparam int CTRL_QUAD     = 21;
  localparam int CTRL_READ     = 22;
  localparam int CTRL_WRITE    = 23;
  localparam int CTRL_ADDRESS  = 24;
  localparam int CTRL_GO       = 31;

  function automatic logic [4:0] regIndex(input logic [31:0] addr);
    logic [4:0] idx;
    idx = IDX_NONE;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (REG_ADDR[i] == addr) idx = 5'(i);
    end
    return idx;
  endfunction : regIndex

  function automatic logic [7:0] mergeByte(input logic [4:0] idx, input logic [7:0] old, input logic [7:0] wd);
    logic [7:0] ro;
    logic [7:0] otp;
    ro  = REG_RO_MASK[idx];
    otp = REG_OTP_MASK[idx];
    return (old & ro) | (wd & ~ro & ~otp) | (old & wd & otp);
  endfunction : mergeByte
endpackage : sfr_pkg

// File: hdl/sfr_link_if.sv
// Purpose: Serial link between host controller and register device
// Assumes: Undriven data lines float high
// Notes:   Line level is worked out here from both enables
`timescale 1ns/100ps
interface sfr_link_if;
  logic       csN;
  logic       sck;
  logic [3:0] hostDq;
  logic [3:0] hostDqOe;
  logic [3:0] devDq;
  logic [3:0] devDqOe;
  logic [3:0] dq;

  for (genvar i = 0; i < 4; i++) begin : g_line
    assign dq[i] = hostDqOe[i] ? hostDq[i] : (devDqOe[i] ? devDq[i] : 1'b1);
  end

  modport host (output csN, output sck, output hostDq, output hostDqOe, input dq);
  modport device (input csN, input sck, input dq, output devDq, output devDqOe);
endinterface : sfr_link_if

// File: hdl/sfr_device.sv
// Purpose: Device end: generic register read and write commands
// Assumes: Link pins arrive asynchronously, sampled by clk
// Notes:   Data sampled on sck rise, driven after sck fall
`timescale 1ns/100ps
// Notes on behaviour
// (R1) Read: 65h, address, latency dummies, data
// (R2) Address is 3 or 4 bytes by config
// (R3) Same register byte repeats while selected
// (R4) Unmapped read address returns undefined data
// (R5) Register read works during busy periods
// (R6) Host avoids reading array window registers
// (R7) Password reads invalid in password mode
// (R8) Quad mode: instruction on four lines
// (R9) Write: 71h, address, one data byte
// (R10) Write needs write enable latch set
// (R11) Read-only bits ignored, no error
// (R12) OTP bits only leave default state
// (R13) Non-volatile update timed; failure sets flags
// (R14) Volatile bits update almost at once
// (R15) Busy bit 0, errors bits 6,5
// (R16) After failure, clear status ends busy
// (R17) Lock register ignores generic writes
// (R18) Write framed like one-byte page program
// (R19) Write uses the read address map
// (R20) Executes only if select rises after byte
// (R21) Finished write clears write enable latch
module sfr_device #(
  parameter int NV_CYCLES = sfr_pkg::NV_WRITE_CYCLES
) (
  // System
  input  wire logic clk,
  input  wire logic reset,
  // Link
  sfr_link_if.device link,
  // User side
  input  wire logic quadMode,
  input  wire logic eraseFail,
  input  wire logic programFail,
  output wire logic busy
);
  import sfr_pkg::*;

  typedef enum {D_CMD, D_ADDR, D_DUMMY, D_IN, D_OUT, D_SKIP} sfr_dev_state_t;

  logic [2:0]     csSync;
  logic [2:0]     sckSync;
  logic [2:0]     dqSync [4];
  logic           csLevel;
  logic           sckLevel;
  sfr_dev_state_t state;
  logic [5:0]     cnt;
  logic [31:0]    shiftIn;
  logic [7:0]     opcode;
  logic [4:0]     addrIdx;
  logic [7:0]     dataByte;
  logic           cmdDone;
  logic [2:0]     outPos;
  logic           outBit;
  logic           outOe;
  logic [7:0]     regs [REG_COUNT];
  logic           nvActive;
  logic [31:0]    nvTimer;
  logic [4:0]     pendIdx;
  logic [7:0]     pendVal;

  wire        csNow    = (csSync[2] == csSync[1]) ? csSync[2] : csLevel;
  wire        sckNow   = (sckSync[2] == sckSync[1]) ? sckSync[2] : sckLevel;
  wire        csRise   = csNow & ~csLevel;
  wire        sckRise  = sckNow & ~sckLevel & ~csLevel;
  wire        sckFall  = ~sckNow & sckLevel & ~csLevel;
  wire [3:0]  dqIn     = {dqSync[3][2], dqSync[2][2], dqSync[1][2], dqSync[0][2]};
  wire [5:0]  cmdStep  = quadMode ? 6'd4 : 6'd1;
  wire [7:0]  cmdByte  = quadMode ? {shiftIn[3:0], dqIn} : {shiftIn[6:0], dqIn[0]};
  wire        cmdLast  = (cnt + cmdStep) == 6'd8;
  wire [7:0]  cfgTwo   = regs[IDX_VCR2];
  wire [5:0]  addrBits = cfgTwo[BIT_ADDR4] ? 6'd32 : 6'd24;
  wire [3:0]  latency  = cfgTwo[LAT_MSB:0];
  wire [31:0] addrWord = {shiftIn[30:0], dqIn[0]} & (cfgTwo[BIT_ADDR4] ? 32'hFFFF_FFFF : 32'h00FF_FFFF);
  wire        isRead   = opcode == OP_READ_ANY;
  wire        isWrite  = opcode == OP_WRITE_ANY;
  wire        oneByte  = (cmdByte == OP_WR_EN) | (cmdByte == OP_WRDI) | (cmdByte == OP_CLSR) |
                         (cmdByte == OP_CLSR_ALT);
  wire [7:0]  status   = regs[IDX_VSR1];
  wire        running  = status[BIT_RUN];
  wire        armed    = status[BIT_ARM];
  wire        pwMode   = ~regs[IDX_PROT][BIT_PWMODE];
  wire        isPass   = (addrIdx >= IDX_PASS0) && (addrIdx <= IDX_PASS7);
  wire        execNow  = csRise & cmdDone;
  wire        nvDone   = nvActive && (nvTimer == 32'd0);
  wire        wrOk     = execNow && isWrite && armed && !running && (addrIdx != IDX_NONE) &&
                         (addrIdx != IDX_LOCK);
  wire        wrNv     = addrIdx < IDX_VFIRST;
  wire [7:0]  wrMerged = mergeByte(addrIdx, regs[addrIdx], dataByte);
  wire [7:0]  readVal  = (addrIdx == IDX_NONE) ? INVALID_DATA :                  // [R4]
                         (isPass && pwMode) ? INVALID_DATA : regs[addrIdx];      // [R7]

  assign busy         = running;
  assign link.devDq   = {2'b00, outBit, 1'b0};
  assign link.devDqOe = {2'b00, outOe, 1'b0};

  // Three-stage pin capture; a level changes once stages two and three agree
  always_ff @(posedge clk) begin
    csSync  <= {csSync[1:0], link.csN};
    sckSync <= {sckSync[1:0], link.sck};
    for (int i = 0; i < 4; i++) begin
      dqSync[i] <= {dqSync[i][1:0], link.dq[i]};
    end
    if (reset) begin
      csLevel  <= 1'b1;
      sckLevel <= 1'b0;
    end else begin
      csLevel  <= csNow;
      sckLevel <= sckNow;
    end
  end

  // Command framing; select high aborts any frame
  always_ff @(posedge clk) begin
    if (reset || csLevel) begin
      state   <= D_CMD;
      cnt     <= 6'd0;
      cmdDone <= 1'b0;
      outPos  <= 3'd0;
      outOe   <= 1'b0;
      outBit  <= 1'b0;
      if (reset) begin
        shiftIn  <= 32'h0000_0000;
        opcode   <= 8'h00;
        addrIdx  <= IDX_NONE;
        dataByte <= 8'h00;
      end
    end else if (sckRise) begin
      unique case (state)
        D_CMD: begin
          shiftIn <= quadMode ? {shiftIn[27:0], dqIn} : {shiftIn[30:0], dqIn[0]};  // [R8]
          cnt     <= cnt + cmdStep;
          if (cmdLast) begin
            opcode  <= cmdByte;
            cnt     <= 6'd0;
            cmdDone <= oneByte;
            state   <= ((cmdByte == OP_READ_ANY) || (cmdByte == OP_WRITE_ANY)) ? D_ADDR : D_SKIP;  // [R1] [R9]
          end
        end
        D_ADDR: begin
          shiftIn <= {shiftIn[30:0], dqIn[0]};
          cnt     <= cnt + 6'd1;
          if (cnt == addrBits - 6'd1) begin                                 // [R2]
            addrIdx <= regIndex(addrWord);                                  // [R19]
            cnt     <= 6'd0;
            state   <= isWrite ? D_IN : ((latency == 4'd0) ? D_OUT : D_DUMMY);
          end
        end
        D_DUMMY: begin
          cnt <= cnt + 6'd1;
          if (cnt == {2'b00, latency} - 6'd1) state <= D_OUT;              // [R1]
        end
        D_IN: begin
          shiftIn <= {shiftIn[30:0], dqIn[0]};
          cnt     <= cnt + 6'd1;
          if (cnt == 6'd7) begin                                            // [R18]
            dataByte <= {shiftIn[6:0], dqIn[0]};
            cmdDone  <= 1'b1;
            state    <= D_SKIP;
          end
        end
        D_SKIP: cmdDone <= 1'b0;                                            // [R20]
        D_OUT: cnt <= cnt;
      endcase
    end else if (sckFall && (state == D_OUT)) begin
      outOe  <= 1'b1;
      outBit <= readVal[3'd7 - outPos];                                     // [R3] [R5]
      outPos <= outPos + 3'd1;
    end
  end

  // Register store, status flags and timed non-volatile update
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RESET[i];
      end
      nvActive <= 1'b0;
      nvTimer  <= 32'd0;
      pendIdx  <= IDX_NONE;
      pendVal  <= 8'h00;
    end else begin
      if (nvActive && (nvTimer != 32'd0)) nvTimer <= nvTimer - 32'd1;
      if (execNow && !running && (opcode == OP_WR_EN)) regs[IDX_VSR1][BIT_ARM] <= 1'b1;
      if (execNow && !running && (opcode == OP_WRDI)) regs[IDX_VSR1][BIT_ARM] <= 1'b0;
      if (execNow && ((opcode == OP_CLSR) || (opcode == OP_CLSR_ALT))) begin
        regs[IDX_VSR1][BIT_EERR] <= 1'b0;                                   // [R16]
        regs[IDX_VSR1][BIT_PERR] <= 1'b0;
        if ((status[BIT_EERR] | status[BIT_PERR]) && !nvActive) regs[IDX_VSR1][BIT_RUN] <= 1'b0;
      end
      if (wrOk && wrNv) begin                                               // [R10] [R17]
        nvActive                <= 1'b1;
        nvTimer                 <= 32'(NV_CYCLES - 1);
        pendIdx                 <= addrIdx;
        pendVal                 <= wrMerged;                                // [R11] [R12]
        regs[IDX_VSR1][BIT_RUN] <= 1'b1;                                    // [R15]
      end else if (wrOk) begin
        regs[addrIdx]           <= wrMerged;                                // [R14]
        regs[IDX_VSR1][BIT_ARM] <= 1'b0;                                    // [R21]
      end
      // Completion is placed last so a set beats a same-cycle clear
      if (nvDone) begin
        nvActive <= 1'b0;
        if (eraseFail) begin
          regs[IDX_VSR1][BIT_EERR] <= 1'b1;                                 // [R13]
        end else if (programFail) begin
          regs[IDX_VSR1][BIT_PERR] <= 1'b1;
        end else begin
          regs[pendIdx]           <= pendVal;
          regs[IDX_VSR1][BIT_RUN] <= 1'b0;
          regs[IDX_VSR1][BIT_ARM] <= 1'b0;                                  // [R21]
        end
      end
    end
  end
endmodule : sfr_device

// File: hdl/sfr_host.sv
// Purpose: Host end: runs one framed command per software request
// Assumes: Software uses the plain register port
// Notes:   sck made by dividing clk; read data sampled late in high phase
`timescale 1ns/100ps
module sfr_host (
  // System
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // Link
  sfr_link_if.host         link
);
  import sfr_pkg::*;

  typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP} sfr_host_state_t;

  sfr_host_state_t state;
  logic [31:0]     ctrl;
  logic [31:0]     addrReg;
  logic [7:0]      rdShift;
  logic [7:0]      timer;
  logic [6:0]      cyc;
  logic [2:0]      dqSync;
  logic            csN;
  logic            sck;
  logic [3:0]      dqOut;
  logic [3:0]      dqOe;

  wire [6:0] instrCyc = ctrl[CTRL_QUAD] ? 7'd2 : 7'd8;                      // [R8]
  wire [6:0] addrCyc  = ctrl[CTRL_ADDRESS] ? (ctrl[CTRL_ADDR4] ? 7'd32 : 7'd24) : 7'd0;  // [R2]
  wire [6:0] latCyc   = ctrl[CTRL_READ] ? {3'b000, ctrl[CTRL_LAT_LSB +: 4]} : 7'd0;     // [R1]
  wire [6:0] dataCyc  = (ctrl[CTRL_READ] | ctrl[CTRL_WRITE]) ? 7'd8 : 7'd0; // [R9]
  wire [6:0] addrEnd  = instrCyc + addrCyc;
  wire [6:0] dataBeg  = addrEnd + latCyc;
  wire [6:0] lastCyc  = dataBeg + dataCyc - 7'd1;
  wire       halfDone = timer == 8'd0;
  wire       goReq    = regWrite && (regAddr == HREG_CTRL) && regWdata[CTRL_GO] && (state == H_IDLE);

  // Line values for one bit cycle: {enables, levels}
  function automatic logic [7:0] driveFor(input logic [6:0] k);
    logic [6:0] j;
    j = 7'd0;
    if (k < instrCyc) begin
      if (ctrl[CTRL_QUAD]) return {4'hF, (k == 7'd0) ? ctrl[7:4] : ctrl[3:0]};
      j = 7'd7 - k;
      return {4'h1, 3'b000, ctrl[j[2:0]]};
    end else if (k < addrEnd) begin
      j = addrEnd - 7'd1 - k;
      return {4'h1, 3'b000, addrReg[j[4:0]]};
    end else if (k >= dataBeg && ctrl[CTRL_WRITE]) begin
      j = lastCyc - k;
      return {4'h1, 3'b000, regWdataHold(j[2:0])};
    end
    return 8'h10;
  endfunction : driveFor

  function automatic logic regWdataHold(input logic [2:0] b);
    return ctrl[CTRL_DATA_LSB + 32'(b)];
  endfunction : regWdataHold

  assign link.csN     = csN;
  assign link.sck     = sck;
  assign link.hostDq  = dqOut;
  assign link.hostDqOe = dqOe;

  always_ff @(posedge clk) begin
    dqSync <= {dqSync[1:0], link.dq[1]};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl     <= 32'h0000_0000;
      addrReg  <= 32'h0000_0000;
      regRdata <= 32'h0000_0000;
    end else begin
      if (regWrite && (regAddr == HREG_CTRL) && (state == H_IDLE)) ctrl <= regWdata;
      if (regWrite && (regAddr == HREG_ADDR) && (state == H_IDLE)) addrReg <= regWdata;
      regRdata <= 32'h0000_0000;
      if (regRead && (regAddr == HREG_CTRL)) regRdata <= ctrl;
      if (regRead && (regAddr == HREG_ADDR)) regRdata <= addrReg;
      if (regRead && (regAddr == HREG_STATUS)) regRdata <= {16'h0000, rdShift, 7'h00, state != H_IDLE};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state   <= H_IDLE;
      timer   <= 8'd0;
      cyc     <= 7'd0;
      csN     <= 1'b1;
      sck     <= 1'b0;
      dqOut   <= 4'h0;
      dqOe    <= 4'h0;
      rdShift <= 8'h00;
    end else begin
      if (!halfDone) timer <= timer - 8'd1;
      unique case (state)
        H_IDLE: if (goReq) begin
          csN   <= 1'b0;
          cyc   <= 7'd0;
          timer <= 8'(SCK_HALF_CYCLES - 1);
          state <= H_LEAD;
        end
        H_LEAD: if (halfDone) begin
          {dqOe, dqOut} <= driveFor(cyc);
          timer <= 8'(SCK_HALF_CYCLES - 1);
          state <= H_LOW;
        end
        H_LOW: if (halfDone) begin
          sck   <= 1'b1;
          timer <= 8'(SCK_HALF_CYCLES - 1);
          state <= H_HIGH;
        end
        H_HIGH: if (halfDone) begin
          sck   <= 1'b0;
          timer <= 8'(SCK_HALF_CYCLES - 1);
          if (ctrl[CTRL_READ] && cyc >= dataBeg) rdShift <= {rdShift[6:0], dqSync[2]};
          if (cyc == lastCyc) begin
            state <= H_TAIL;
          end else begin
            cyc           <= cyc + 7'd1;
            {dqOe, dqOut} <= driveFor(cyc + 7'd1);
            state         <= H_LOW;
          end
        end
        H_TAIL: if (halfDone) begin
          csN   <= 1'b1;                                                    // [R20]
          dqOe  <= 4'h0;
          timer <= 8'(CS_GAP_CYCLES - 1);
          state <= H_GAP;
        end
        H_GAP: if (halfDone) state <= H_IDLE;
      endcase
    end
  end
endmodule : sfr_host

// File: dv/sfr_link_checker.sv
// Purpose: Wire-level checks on the link between host end and device end
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Sees only the interface signals
`timescale 1ns/100ps
module sfr_link_checker (
  // System
  input wire logic       clk,
  input wire logic       reset,
  // Link
  input wire logic       csN,
  input wire logic       sck,
  input wire logic [3:0] hostDq,
  input wire logic [3:0] hostDqOe,
  input wire logic [3:0] devDq,
  input wire logic [3:0] devDqOe,
  input wire logic [3:0] dq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_sck_idle: assert property (csN |-> !sck)
    else $error("link clock moves while deselected");
  a_sck_high: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("link clock high phase not four cycles");
  a_sck_low: assert property ($fell(sck) |-> (!sck)[*4])
    else $error("link clock low phase too short");
  a_cs_release: assert property ($rose(csN) |-> !$past(sck, 1) && !$past(sck, 4))
    else $error("select raised inside a bit");
  a_dev_lines: assert property ((devDqOe & 4'b1101) == 4'h0)
    else $error("device drives a line other than line one");
  a_dev_release: assert property (csN[*6] |-> devDqOe == 4'h0)
    else $error("device still drives after deselect");
  a_line_owner: assert property (devDqOe[1] |-> dq[1] == devDq[1])
    else $error("host fights device on read data line");
  a_read_steady: assert property (sck && $past(sck) && devDqOe[1] |-> $stable(devDq[1]))
    else $error("read data moves while link clock high");
  a_host_steady: assert property (sck && $past(sck) && hostDqOe[0] |-> $stable(hostDq))
    else $error("host data moves while link clock high");
  a_host_quiet: assert property (csN[*2] |-> hostDqOe == 4'h0)
    else $error("host drives lines while deselected");
endmodule : sfr_link_checker

// File: dv/tb_top.sv
// Purpose: Self-checking bench joining host end and device end
// Assumes: 10 MHz clock, host makes the link clock
// Notes:   Non-volatile update time shortened through NV_CYCLES
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin badCount++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import sfr_pkg::*;
  localparam int NV = 2000;
  localparam logic [31:0] A_STS1 = 32'h0080_0000;
  localparam logic [31:0] A_VLRN = 32'h0080_0010;
  localparam logic [31:0] A_VCR2 = 32'h0080_0003;
  logic        clk;
  logic        reset;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        quadMode;
  logic        eraseFail;
  logic        programFail;
  logic        busy;
  logic        quad;
  logic        addr4;
  logic [3:0]  lat;
  logic [7:0]  got;
  logic [7:0]  d;
  logic [7:0]  vd;
  integer      seed;
  int          badCount;
  int          samplesChecked;

  sfr_link_if sfr_link_if_inst ();
  sfr_host sfr_host_inst (.clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .link(sfr_link_if_inst.host));
  sfr_device #(.NV_CYCLES(NV)) sfr_device_inst (.clk(clk), .reset(reset), .link(sfr_link_if_inst.device),
    .quadMode(quadMode), .eraseFail(eraseFail), .programFail(programFail), .busy(busy));
  sfr_link_checker sfr_link_checker_inst (.clk(clk), .reset(reset), .csN(sfr_link_if_inst.csN),
    .sck(sfr_link_if_inst.sck), .hostDq(sfr_link_if_inst.hostDq), .hostDqOe(sfr_link_if_inst.hostDqOe),
    .devDq(sfr_link_if_inst.devDq), .devDqOe(sfr_link_if_inst.devDqOe), .dq(sfr_link_if_inst.dq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic endOfTest;
    if (badCount == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : endOfTest

  task automatic regWr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : regWr

  task automatic regRd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask : regRd

  // One framed command; waits for the host to finish it
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input logic [7:0] v,
                       input logic rd, input logic wr, input logic sa);
    logic [31:0] s;
    int          n;
    regWr(HREG_ADDR, a);
    regWr(HREG_CTRL, {1'b1, 6'h00, sa, wr, rd, quad, addr4, lat, v, op});
    n = 0;
    do begin
      regRd(HREG_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 2000);
    `CHK("host done", 1'b0, s[0])
    got = s[15:8];
  endtask : frame

  task automatic readReg(input logic [31:0] a);
    frame(OP_READ_ANY, a, 8'h00, 1'b1, 1'b0, 1'b1);
  endtask : readReg

  task automatic writeReg(input logic [31:0] a, input logic [7:0] v);
    frame(OP_WR_EN, 32'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    frame(OP_WRITE_ANY, a, v, 1'b0, 1'b1, 1'b1);
  endtask : writeReg

  task automatic waitDev;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask : waitDev

  initial begin
    repeat (90000) @(posedge clk);
    badCount++;
    endOfTest();
  end

  initial begin
    seed        = 32'h6CAE;
    reset       = 1'b1;
    regAddr     = 8'h00;
    regWdata    = 32'h0;
    regWrite    = 1'b0;
    regRead     = 1'b0;
    quadMode    = 1'b0;
    eraseFail   = 1'b0;
    programFail = 1'b0;
    quad        = 1'b0;
    addr4       = 1'b0;
    lat         = 4'h8;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    // Only the plain register map is read; window registers are left alone
    for (int i = 0; i < REG_COUNT; i++) begin
      readReg(REG_ADDR[i]);
      `CHK("reset value", REG_RESET[i], got)
    end
    readReg(32'h0000_0001);
    `CHK("unmapped read", INVALID_DATA, got)
    vd = 8'($random(seed));
    frame(OP_WRITE_ANY, A_VLRN, vd, 1'b0, 1'b1, 1'b1);
    readReg(A_VLRN);
    `CHK("write without latch", 8'h00, got)
    writeReg(A_VLRN, vd);
    `CHK("volatile busy", 1'b0, busy)
    readReg(A_VLRN);
    `CHK("volatile write", vd, got)
    readReg(A_STS1);
    `CHK("latch after write", 8'h00, got)
    // Read flag adds dummies, so select rises eight clocks past the byte
    frame(OP_WR_EN, 32'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    frame(OP_WRITE_ANY, A_VLRN, ~vd, 1'b1, 1'b1, 1'b1);
    readReg(A_VLRN);
    `CHK("write with extra clocks", vd, got)
    readReg(A_STS1);
    `CHK("latch kept", 8'h02, got)
    frame(OP_WRDI, 32'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    readReg(A_STS1);
    `CHK("latch after disable", 8'h00, got)
    writeReg(32'h0080_0040, 8'hFE);
    readReg(32'h0080_0040);
    `CHK("lock register", 8'h01, got)
    writeReg(A_STS1, 8'hFF);
    readReg(A_STS1);
    `CHK("read-only status", 8'h00, got)
    d = 8'($random(seed));
    writeReg(32'h0000_0010, d);
    `CHK("nv busy", 1'b1, busy)
    readReg(A_STS1);
    `CHK("status during update", 8'h03, got)
    waitDev();
    `CHK("nv done", 1'b0, busy)
    readReg(32'h0000_0010);
    `CHK("nv write", d, got)
    readReg(A_STS1);
    `CHK("latch after nv write", 8'h00, got)
    d = {1'b0, 7'($random(seed))};
    writeReg(32'h0000_0020, d);
    waitDev();
    readReg(32'h0000_0020);
    `CHK("password byte", d, got)
    writeReg(32'h0000_0030, 8'hFB);
    waitDev();
    writeReg(32'h0000_0030, 8'hFF);
    waitDev();
    readReg(32'h0000_0030);
    `CHK("one-time bits", 8'hFB, got)
    readReg(32'h0000_0020);
    `CHK("hidden password", INVALID_DATA, got)
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      eraseFail   <= (k == 0);
      programFail <= (k == 1);
      writeReg(32'h0000_0010, 8'($random(seed)));
      waitDev();
      readReg(A_STS1);
      `CHK("fail flags", (k == 0) ? 8'h21 : 8'h41, got & 8'h61)
      `CHK("busy after fail", 1'b1, busy)
      @(posedge clk);
      eraseFail   <= 1'b0;
      programFail <= 1'b0;
      frame((k == 0) ? OP_CLSR : OP_CLSR_ALT, 32'h0, 8'h00, 1'b0, 1'b0, 1'b0);
      waitDev();
      `CHK("busy after clear", 1'b0, busy)
      readReg(A_STS1);
      `CHK("flags after clear", 8'h00, got & 8'h61)
    end
    d = {4'h8, 4'(1 + ($unsigned($random(seed)) % 15))};
    writeReg(A_VCR2, d);
    addr4 = 1'b1;
    lat   = d[3:0];
    readReg(A_VCR2);
    `CHK("four-byte config", d, got)
    readReg(A_VLRN);
    `CHK("four-byte read", vd, got)
    @(posedge clk);
    quadMode <= 1'b1;
    quad = 1'b1;
    readReg(A_VCR2);
    `CHK("quad instruction", d, got)
    writeReg(A_VCR2, 8'h80);
    lat = 4'h0;
    readReg(A_VCR2);
    `CHK("zero latency", 8'h80, got)
    @(posedge clk);
    quadMode <= 1'b0;
    quad = 1'b0;
    endOfTest();
  end
endmodule : tb_top
